//--- adc_corr_pkg.sv
// Shared constants and carrier types for the converter register block
package adc_corr_pkg;
    localparam int DATA_W      = 32;
    localparam int AXI_ADDR_W  = 8;
    localparam int COEF_W      = 24;
    localparam int RESULT_BITS = 18;
    localparam int RESULT_PAD  = COEF_W - RESULT_BITS;
    localparam int COEF_FRAC   = 22;
    localparam int CALC_W      = 56;
    localparam int PORTS       = 4;
    localparam int UNI_SHIFT   = 5;
    localparam int BI_SHIFT    = 6;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CONV_CTRL = 4'h1;
    localparam logic [3:0] IDX_GPIO      = 4'h2;
    localparam logic [3:0] IDX_CORR_CTRL = 4'h3;
    localparam logic [3:0] IDX_RESULT    = 4'h4;
    localparam logic [3:0] IDX_SYS_OFS   = 4'h5;
    localparam logic [3:0] IDX_SYS_GAIN  = 4'h6;
    localparam logic [3:0] IDX_SELF_OFS  = 4'h7;
    localparam logic [3:0] IDX_SELF_GAIN = 4'h8;

    localparam int GPIO_DIR_LSB      = 4;
    localparam int DGAIN_LSB         = 5;
    localparam int SYS_GAIN_DIS_BIT  = 4;
    localparam int SYS_OFS_DIS_BIT   = 3;
    localparam int SELF_GAIN_DIS_BIT = 2;
    localparam int SELF_OFS_DIS_BIT  = 1;
    localparam int RANGE_BIT         = 6;
    localparam int FORMAT_BIT        = 2;

    localparam logic [7:0]  GPIO_RST     = 8'h0f;
    localparam logic [7:0]  CORR_RST     = 8'h1e;
    localparam logic [7:0]  CONV_RST     = 8'h02;
    localparam logic [7:0]  CORR_WR_MASK = 8'hfe;
    localparam logic [23:0] COEF_RST     = 24'h000000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic        unipolar;
        logic        offset_binary;
        logic [2:0]  dgain;
        logic        sys_gain_dis;
        logic        sys_ofs_dis;
        logic        self_gain_dis;
        logic        self_ofs_dis;
        logic [23:0] sys_ofs;
        logic [23:0] sys_gain;
        logic [23:0] self_ofs;
        logic [23:0] self_gain;
    } corr_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] value;
    } sample_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] coeff;
    } chain_state_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [7:0]  conv_ctrl;
        logic [7:0]  gpio;
        logic [7:0]  corr_ctrl;
        logic [23:0] sys_ofs;
        logic [23:0] sys_gain;
        logic [23:0] self_ofs;
        logic [23:0] self_gain;
        logic [3:0]  pin_meta;
        logic [3:0]  pin_sync;
        logic [3:0]  port_value;
        logic [3:0]  port_oe_n;
    } regs_state_t;
endpackage

//--- adc_correction_chain.sv
// Calibration correction, digital gain, encoding and clipping of one sample
`timescale 1ns/1ps
module adc_correction_chain
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    input  wire adc_corr_pkg::corr_cfg_t cfg_i,
    input  wire adc_corr_pkg::sample_t sample_i,
    output logic [23:0]               result_o,
    output logic                      result_valid_o
);
    adc_corr_pkg::chain_state_t st;
    adc_corr_pkg::chain_state_t next_st;

    logic signed [55:0] a;
    logic signed [55:0] b;
    logic signed [55:0] c;
    logic signed [55:0] d;
    logic signed [55:0] e;
    logic signed [55:0] f;
    logic signed [55:0] code;
    logic signed [55:0] lo;
    logic signed [55:0] hi;
    logic [17:0]        q;

    always_comb
    begin
        next_st = st;
        next_st.valid = sample_i.valid;
        a = 56'(signed'(sample_i.value));
        if (!cfg_i.self_ofs_dis)
            a = a - 56'(signed'(cfg_i.self_ofs));
        b = cfg_i.self_gain_dis ? a
          : (a * 56'(signed'(cfg_i.self_gain))) >>> adc_corr_pkg::COEF_FRAC;
        c = b;
        if (!cfg_i.sys_ofs_dis)
            c = b - 56'(signed'(cfg_i.sys_ofs));
        d = cfg_i.sys_gain_dis ? c
          : (c * 56'(signed'(cfg_i.sys_gain))) >>> adc_corr_pkg::COEF_FRAC;
        // Range scale comes after the system offset
        e = cfg_i.unipolar ? (d <<< 1) : d;
        f = e <<< cfg_i.dgain;
        if (cfg_i.unipolar)
        begin
            code = f >>> adc_corr_pkg::UNI_SHIFT;
            lo   = 56'sh0;
            hi   = 56'sh3ffff;
        end
        else
        begin
            code = f >>> adc_corr_pkg::BI_SHIFT;
            lo   = -56'sh20000;
            hi   = 56'sh1ffff;
        end
        // Saturate rather than wrap
        if (code < lo)
            code = lo;
        else if (code > hi)
            code = hi;
        q = code[17:0];
        if (!cfg_i.unipolar && cfg_i.offset_binary)
            q = {~code[17], code[16:0]};
        if (sample_i.valid)
            next_st.coeff = {q, {adc_corr_pkg::RESULT_PAD{1'b0}}};
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st <= '{valid: 1'b0, coeff: adc_corr_pkg::COEF_RST};
        else if (ce_i)
            st <= next_st;
    end

    assign result_o       = st.coeff;
    assign result_valid_o = st.valid;
endmodule

//--- adc_corr_regs.sv
// AXI4-Lite register block with GPIO ports and correction control
//
// Overview of operation
// - Input port reads pin level
// - Output port drives its data bit
// - Four ports; direction high nibble; reset values
// - Gain is two to the field
// - Digital gain applied after all corrections
// - System gain disable bit skips coefficient
// - System offset disable bit skips coefficient
// - Self gain disable bit skips coefficient
// - Self offset disable bit skips subtraction
// - Result register read-only, writes ignored
// - Eighteen result bits top, six zero
// - Unipolar range uses straight binary
// - Format bit picks offset binary/two's complement
// - Two's complement full-scale codes
// - Offset binary full-scale codes
// - Out of range results saturate
// - System offset 24-bit, signed, resets zero
// - System offset kept until rewrite/calibration
// - System offset after self corrections
// - System offset before range scale
// - Range bit: one unipolar, zero bipolar
// - System gain scales up to two
// - Self offset subtracted first
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module adc_corr_regs
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ce_i,
    input  wire logic [7:0]                awaddr_i,
    input  wire logic                      awvalid_i,
    output logic                           awready_o,
    input  wire logic [31:0]               wdata_i,
    input  wire logic [3:0]                wstrb_i,
    input  wire logic                      wvalid_i,
    output logic                           wready_o,
    output logic [1:0]                     bresp_o,
    output logic                           bvalid_o,
    input  wire logic                      bready_i,
    input  wire logic [7:0]                araddr_i,
    input  wire logic                      arvalid_i,
    output logic                           arready_o,
    output logic [31:0]                    rdata_o,
    output logic [1:0]                     rresp_o,
    output logic                           rvalid_o,
    input  wire logic                      rready_i,
    input  wire adc_corr_pkg::sample_t     sample_i,
    input  wire adc_corr_pkg::sample_t     sys_cal_i,
    input  wire logic [3:0]                gpio_pin_i,
    output logic [3:0]                     port_value_o,
    output logic [3:0]                     port_oe_n_o,
    output logic                           result_valid_o
);
    adc_corr_pkg::regs_state_t st;
    adc_corr_pkg::regs_state_t next_st;
    adc_corr_pkg::corr_cfg_t   cfg;

    logic [23:0] result;
    logic [31:0] bmask;
    logic [3:0]  widx;
    logic        wmapped;

    // Index of an address, or zero when nothing lives there
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [3:0] idx;
        idx = addr[5:2];
        if (addr[7:6] != 2'h0)
            idx = 4'h0;
        else if (idx > adc_corr_pkg::IDX_SELF_GAIN)
            idx = 4'h0;
        return idx;
    endfunction

    function automatic logic [31:0] read_reg(
        input logic [3:0]                idx,
        input adc_corr_pkg::regs_state_t s,
        input logic [23:0]               res
    );
        logic [31:0] v;
        logic [3:0]  dir;
        v   = 32'h0;
        dir = s.gpio[7:adc_corr_pkg::GPIO_DIR_LSB];
        unique case (idx)
            adc_corr_pkg::IDX_CONV_CTRL:
                v[7:0] = s.conv_ctrl;
            adc_corr_pkg::IDX_GPIO:
                v[7:0] = {dir, (dir & s.gpio[3:0]) | (~dir & s.pin_sync)};
            adc_corr_pkg::IDX_CORR_CTRL:
                v[7:0] = s.corr_ctrl & adc_corr_pkg::CORR_WR_MASK;
            adc_corr_pkg::IDX_RESULT:
                v[23:0] = res;
            adc_corr_pkg::IDX_SYS_OFS:
                v[23:0] = s.sys_ofs;
            adc_corr_pkg::IDX_SYS_GAIN:
                v[23:0] = s.sys_gain;
            adc_corr_pkg::IDX_SELF_OFS:
                v[23:0] = s.self_ofs;
            adc_corr_pkg::IDX_SELF_GAIN:
                v[23:0] = s.self_gain;
            default:
                v = 32'h0;
        endcase
        return v;
    endfunction

    // Control fields handed to the datapath
    always_comb
    begin
        cfg.unipolar      = st.conv_ctrl[adc_corr_pkg::RANGE_BIT];
        cfg.offset_binary = st.conv_ctrl[adc_corr_pkg::FORMAT_BIT];
        cfg.dgain         = st.corr_ctrl[7:adc_corr_pkg::DGAIN_LSB];
        cfg.sys_gain_dis  = st.corr_ctrl[adc_corr_pkg::SYS_GAIN_DIS_BIT];
        cfg.sys_ofs_dis   = st.corr_ctrl[adc_corr_pkg::SYS_OFS_DIS_BIT];
        cfg.self_gain_dis = st.corr_ctrl[adc_corr_pkg::SELF_GAIN_DIS_BIT];
        cfg.self_ofs_dis  = st.corr_ctrl[adc_corr_pkg::SELF_OFS_DIS_BIT];
        cfg.sys_ofs       = st.sys_ofs;
        cfg.sys_gain      = st.sys_gain;
        cfg.self_ofs      = st.self_ofs;
        cfg.self_gain     = st.self_gain;
    end

    adc_correction_chain u_chain
    (
        .sys_clk_i      (sys_clk_i),
        .rst_n_i        (rst_n_i),
        .ce_i           (ce_i),
        .cfg_i          (cfg),
        .sample_i       (sample_i),
        .result_o       (result),
        .result_valid_o (result_valid_o)
    );

    always_comb
    begin
        bmask   = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
        widx    = reg_index(st.awaddr);
        wmapped = (widx != 4'h0);
    end

    always_comb
    begin
        next_st = st;

        // Pin levels come from outside this clock domain
        next_st.pin_meta = gpio_pin_i;
        next_st.pin_sync = st.pin_meta;

        // Address and data are taken in either order
        if (awvalid_i && st.awready)
        begin
            next_st.aw_got  = 1'b1;
            next_st.awaddr  = awaddr_i;
            next_st.awready = 1'b0;
        end
        if (wvalid_i && st.wready)
        begin
            next_st.w_got  = 1'b1;
            next_st.wdata  = wdata_i;
            next_st.wstrb  = wstrb_i;
            next_st.wready = 1'b0;
        end

        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = wmapped ? adc_corr_pkg::RESP_OKAY : adc_corr_pkg::RESP_SLVERR;
            unique case (widx)
                adc_corr_pkg::IDX_CONV_CTRL:
                    next_st.conv_ctrl = (st.conv_ctrl & ~bmask[7:0])
                                      | (st.wdata[7:0] & bmask[7:0]);
                adc_corr_pkg::IDX_GPIO:
                    next_st.gpio = (st.gpio & ~bmask[7:0])
                                 | (st.wdata[7:0] & bmask[7:0]);
                adc_corr_pkg::IDX_CORR_CTRL:
                    next_st.corr_ctrl = ((st.corr_ctrl & ~bmask[7:0])
                                      | (st.wdata[7:0] & bmask[7:0]))
                                      & adc_corr_pkg::CORR_WR_MASK;
                adc_corr_pkg::IDX_SYS_OFS:
                    next_st.sys_ofs = (st.sys_ofs & ~bmask[23:0])
                                    | (st.wdata[23:0] & bmask[23:0]);
                adc_corr_pkg::IDX_SYS_GAIN:
                    next_st.sys_gain = (st.sys_gain & ~bmask[23:0])
                                     | (st.wdata[23:0] & bmask[23:0]);
                adc_corr_pkg::IDX_SELF_OFS:
                    next_st.self_ofs = (st.self_ofs & ~bmask[23:0])
                                     | (st.wdata[23:0] & bmask[23:0]);
                adc_corr_pkg::IDX_SELF_GAIN:
                    next_st.self_gain = (st.self_gain & ~bmask[23:0])
                                      | (st.wdata[23:0] & bmask[23:0]);
                default:
                    next_st.conv_ctrl = st.conv_ctrl;
            endcase
        end

        if (st.bvalid && bready_i)
        begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // A fresh calibration result beats a host write in the same cycle
        if (sys_cal_i.valid)
            next_st.sys_ofs = sys_cal_i.value;

        if (arvalid_i && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = read_reg(reg_index(araddr_i), st, result);
            next_st.rresp   = (reg_index(araddr_i) != 4'h0)
                            ? adc_corr_pkg::RESP_OKAY : adc_corr_pkg::RESP_SLVERR;
        end
        else if (st.rvalid && rready_i)
        begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        // Pins take the new register value on the same edge as the register
        next_st.port_value = next_st.gpio[3:0];
        next_st.port_oe_n  = ~next_st.gpio[7:adc_corr_pkg::GPIO_DIR_LSB];
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st           <= '0;
            st.awready   <= 1'b1;
            st.wready    <= 1'b1;
            st.arready   <= 1'b1;
            st.conv_ctrl <= adc_corr_pkg::CONV_RST;
            st.gpio      <= adc_corr_pkg::GPIO_RST;
            st.corr_ctrl <= adc_corr_pkg::CORR_RST;
            st.sys_ofs   <= adc_corr_pkg::COEF_RST;
            st.sys_gain  <= adc_corr_pkg::COEF_RST;
            st.self_ofs  <= adc_corr_pkg::COEF_RST;
            st.self_gain <= adc_corr_pkg::COEF_RST;
            st.port_value <= adc_corr_pkg::GPIO_RST[3:0];
            st.port_oe_n  <= 4'hf;
        end
        else if (ce_i)
        begin
            st <= next_st;
        end
    end

    assign awready_o    = st.awready;
    assign wready_o     = st.wready;
    assign bresp_o      = st.bresp;
    assign bvalid_o     = st.bvalid;
    assign arready_o    = st.arready;
    assign rdata_o      = st.rdata;
    assign rresp_o      = st.rresp;
    assign rvalid_o     = st.rvalid;
    assign port_value_o = st.port_value;
    assign port_oe_n_o  = st.port_oe_n;
endmodule

//--- adc_corr_regs_assertions.sv
// Port-level checks for the converter register block
`timescale 1ns/1ps
module adc_corr_regs_assertions
(
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  awaddr_i,
    input wire logic        awvalid_i,
    input wire logic        awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic        wvalid_i,
    input wire logic        wready_o,
    input wire logic [1:0]  bresp_o,
    input wire logic        bvalid_o,
    input wire logic [7:0]  araddr_i,
    input wire logic        arvalid_i,
    input wire logic        arready_o,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0]  rresp_o,
    input wire logic        rvalid_o,
    input wire logic [3:0]  gpio_pin_i,
    input wire logic [3:0]  port_value_o,
    input wire logic [3:0]  port_oe_n_o
);
    logic [5:0]  rd_idx;
    logic [5:0]  wr_idx;
    logic [31:0] wr_word;
    logic [3:0]  age;
    // Remember what each transfer targeted
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_idx  <= 6'h00;
            wr_idx  <= 6'h00;
            wr_word <= 32'h0;
            age     <= 4'h0;
        end
        else
        begin
            if (arvalid_i && arready_o) rd_idx <= araddr_i[7:2];
            if (awvalid_i && awready_o) wr_idx <= awaddr_i[7:2];
            if (wvalid_i && wready_o) wr_word <= wdata_i;
            if (age != 4'hf) age <= age + 4'h1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_result_pad;
        rvalid_o && rd_idx == 6'h04 |-> rdata_o[5:0] == 6'h00 && rdata_o[31:24] == 8'h00;
    endproperty
    a_result_pad: assert property (p_result_pad) else $error("result pad bits set");
    property p_bit0;
        rvalid_o && rd_idx == 6'h03 |-> rdata_o[0] == 1'b0 && rdata_o[31:8] == 24'h0;
    endproperty
    a_bit0: assert property (p_bit0) else $error("control bit zero set");
    // Pins pass two flops, so read data shows the pin three edges back
    property p_input_read;
        $rose(rvalid_o) && rd_idx == 6'h02 && age > 4'h5
            |-> ((rdata_o[3:0] ^ $past(gpio_pin_i, 3)) & ~rdata_o[7:4]) == 4'h0;
    endproperty
    a_input_read: assert property (p_input_read) else $error("input port read wrong");
    property p_output_read;
        rvalid_o && rd_idx == 6'h02 |-> rdata_o[7:4] == ~port_oe_n_o
            && ((rdata_o[3:0] ^ port_value_o) & ~port_oe_n_o) == 4'h0;
    endproperty
    a_output_read: assert property (p_output_read) else $error("port drive mismatch");
    property p_reset_ports;
        disable iff (1'b0) !rst_n_i |-> port_oe_n_o == 4'hf && port_value_o == 4'hf;
    endproperty
    a_reset_ports: assert property (p_reset_ports) else $error("port reset state wrong");
    property p_gpio_write;
        $rose(bvalid_o) && wr_idx == 6'h02 |-> port_oe_n_o == ~wr_word[7:4]
            && ((port_value_o ^ wr_word[3:0]) & ~port_oe_n_o) == 4'h0;
    endproperty
    a_gpio_write: assert property (p_gpio_write) else $error("ports not updated");
    property p_offset_read;
        rvalid_o && rd_idx == 6'h05 |-> rdata_o[31:24] == 8'h00 && rresp_o == 2'h0;
    endproperty
    a_offset_read: assert property (p_offset_read) else $error("offset read wrong");
    property p_result_write;
        $rose(bvalid_o) && wr_idx == 6'h04 |-> bresp_o == 2'h0;
    endproperty
    a_result_write: assert property (p_result_write) else $error("result write refused");
    c_result_read: cover property (rvalid_o && rd_idx == 6'h04 && rdata_o != 32'h0);
    c_gpio_write: cover property ($rose(bvalid_o) && wr_idx == 6'h02);
    c_input_read: cover property (rvalid_o && rd_idx == 6'h02 && port_oe_n_o != 4'hf);
endmodule
bind adc_corr_regs adc_corr_regs_assertions u_chk
(
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .gpio_pin_i(gpio_pin_i), .port_value_o(port_value_o), .port_oe_n_o(port_oe_n_o)
);

//--- gpio_pin_model.sv
// Board-side model of the four port pins
`timescale 1ns/1ps
module gpio_pin_model
(
    input  wire logic [3:0] port_value_i,
    input  wire logic [3:0] port_oe_n_i,
    input  wire logic [3:0] ext_en_i,
    input  wire logic [3:0] ext_level_i,
    output logic      [3:0] pin_o
);
    // Device drive wins, then an enabled external driver; an undriven pin floats to its pull-up
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!port_oe_n_i[i]) pin_o[i] = port_value_i[i];
            else if (ext_en_i[i]) pin_o[i] = ext_level_i[i];
            else pin_o[i] = 1'b1;
        end
    end
endmodule

//--- test_adc_result_correction_gpio.sv
// Self-checking bench for the converter register block
`timescale 1ns/1ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_adc_result_correction_gpio;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h0;
    logic        wvalid  = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic [3:0]  pin;
    logic [3:0]  port_value;
    logic [3:0]  port_oe_n;
    logic [3:0]  ext_en    = 4'h0;
    logic [3:0]  ext_level = 4'h0;
    logic [1:0]  resp;
    logic        result_valid;
    adc_corr_pkg::sample_t sample  = '0;
    adc_corr_pkg::sample_t sys_cal = '0;
    int          errors     = 0;
    int          num_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    adc_corr_regs DUT
    (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(1'b1), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(1'b1), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(1'b1),
        .sample_i(sample), .sys_cal_i(sys_cal), .gpio_pin_i(pin),
        .port_value_o(port_value), .port_oe_n_o(port_oe_n), .result_valid_o(result_valid)
    );
    gpio_pin_model pins
    (
        .port_value_i(port_value), .port_oe_n_i(port_oe_n), .ext_en_i(ext_en),
        .ext_level_i(ext_level), .pin_o(pin)
    );

    // Response channels stay ready, so only request valids move
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        araddr  <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        `CHECK(rdata, e)
    endtask

    // Result and its one-cycle valid pulse follow the sample edge
    task automatic conv(input logic [23:0] raw);
        sample <= {1'b1, raw};
        @(posedge sys_clk);
        sample.valid <= 1'b0;
        @(posedge sys_clk);
        `CHECK(result_valid, 1'b1)
        @(posedge sys_clk);
        `CHECK(result_valid, 1'b0)
        @(posedge sys_clk);
    endtask

    task automatic t_reset();
        chk_rd(8'h0c, 32'h1e);
        chk_rd(8'h10, 32'h0);
        chk_rd(8'h14, 32'h0);
        chk_rd(8'h08, 32'h0f);
        `CHECK(port_oe_n, 4'hf)
    endtask

    task automatic t_gpio();
        wr(8'h08, 32'ha5, resp);
        `CHECK(port_oe_n, 4'h5)
        `CHECK(port_value & 4'ha, 4'h0)
        ext_en <= 4'hf;
        repeat (4) @(posedge sys_clk);
        chk_rd(8'h08, 32'ha0);
        ext_level <= 4'hf;
        repeat (4) @(posedge sys_clk);
        chk_rd(8'h08, 32'ha5);
        wr(8'h08, 32'hfa, resp);
        `CHECK(port_value, 4'ha)
        wr(8'h3c, 32'h0f, resp);
        `CHECK(resp, adc_corr_pkg::RESP_SLVERR)
        chk_rd(8'h08, 32'hfa);
        wr(8'h08, 32'h0f, resp);
    endtask

    task automatic t_ctrl();
        wr(8'h0c, 32'hff, resp);
        chk_rd(8'h0c, 32'hfe);
        wr(8'h10, 32'hffffff, resp);
        `CHECK(resp, adc_corr_pkg::RESP_OKAY)
        chk_rd(8'h10, 32'h0);
        wr(8'h04, 32'h00, resp);
        for (int g = 0; g < 8; g++)
        begin
            wr(8'h0c, {24'h0, g[2:0], 5'h1e}, resp);
            conv(24'h000040);
            chk_rd(8'h10, 32'h40 << g);
        end
    endtask

    // Columns: range/format byte, correction byte, raw word, expected result
    logic [23:0] fmt [8][4] = '{
        '{24'h00, 24'h1e, 24'h7fffc0, 24'h7fffc0}, '{24'h00, 24'h1e, 24'h800000, 24'h800000},
        '{24'h00, 24'h3e, 24'h7fffc0, 24'h7fffc0}, '{24'h04, 24'h1e, 24'h000000, 24'h800000},
        '{24'h04, 24'h1e, 24'h800000, 24'h000000}, '{24'h40, 24'h1e, 24'h200000, 24'h800000},
        '{24'h40, 24'h1e, 24'hfff000, 24'h000000}, '{24'h40, 24'h1e, 24'h7fffff, 24'hffffc0}};
    task automatic t_format();
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h04, {8'h00, fmt[i][0]}, resp);
            wr(8'h0c, {8'h00, fmt[i][1]}, resp);
            conv(fmt[i][2]);
            chk_rd(8'h10, {8'h00, fmt[i][3]});
        end
    endtask

    // Columns: coefficient address (0 skips), coefficient, correction byte, raw, expected
    logic [23:0] cof [8][5] = '{
        '{24'h14, 24'h000040, 24'h16, 24'h0000c0, 24'h80},
        '{24'h00, 24'h0, 24'h1e, 24'h0000c0, 24'hc0},
        '{24'h1c, 24'h000040, 24'h1c, 24'h0000c0, 24'h80},
        '{24'h20, 24'h200000, 24'h1a, 24'h000100, 24'h80},
        '{24'h18, 24'h200000, 24'h0e, 24'h000100, 24'h80},
        '{24'h00, 24'h0, 24'h06, 24'h000140, 24'h80},
        '{24'h00, 24'h0, 24'h0c, 24'h000140, 24'h80},
        '{24'h00, 24'h0, 24'h2e, 24'h000100, 24'h100}};
    task automatic t_coef();
        wr(8'h04, 32'h00, resp);
        for (int i = 0; i < 8; i++)
        begin
            if (cof[i][0] != 24'h0) wr(cof[i][0][7:0], {8'h00, cof[i][1]}, resp);
            wr(8'h0c, {8'h00, cof[i][2]}, resp);
            conv(cof[i][3]);
            chk_rd(8'h10, {8'h00, cof[i][4]});
        end
        wr(8'h14, 32'hffffc0, resp);
        wr(8'h0c, 32'h16, resp);
        conv(24'h000040);
        chk_rd(8'h10, 32'h80);
        wr(8'h04, 32'h40, resp);
        conv(24'h000040);
        chk_rd(8'h10, 32'h200);
        chk_rd(8'h14, 32'hffffc0);
        sys_cal <= {1'b1, 24'h000100};
        @(posedge sys_clk);
        sys_cal.valid <= 1'b0;
        @(posedge sys_clk);
        chk_rd(8'h14, 32'h100);
    endtask

    task automatic complete_run();
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_gpio();
        t_ctrl();
        t_format();
        t_coef();
        // Mid-run reset must bring back the GPIO, correction, result and system offset defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        complete_run();
    end
endmodule
